// ---- rtl/rup_pkg.sv ----
// shared constants for the remote update parameter block
package rup_pkg;

  // ----------------------------------------------------------------
  // parameter selector codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_STATUS   = 3'h0;
  localparam logic [2:0] SEL_WD_VALUE = 3'h2;
  localparam logic [2:0] SEL_WD_EN    = 3'h3;
  localparam logic [2:0] SEL_PAGE     = 3'h4;
  localparam logic [2:0] SEL_CUR_CFG  = 3'h5;

  localparam int PARAM_W  = 12;
  localparam int STATUS_W = 5;
  localparam int PAGE_W   = 3;
  // shift chain: status(5) cur_cfg(1) page(3) wd_en(1) wd_value(12)
  localparam int CHAIN_W  = 22;
  localparam int POS_WDV  = 0;
  localparam int POS_WDE  = 12;
  localparam int POS_PAGE = 13;
  localparam int POS_CFG  = 16;
  localparam int POS_STAT = 17;

  // ----------------------------------------------------------------
  // status cause bits
  // ----------------------------------------------------------------
  localparam int CAUSE_CRC   = 0;
  localparam int CAUSE_STAT  = 1;
  localparam int CAUSE_CORE  = 2;
  localparam int CAUSE_REQ   = 3;
  localparam int CAUSE_WDOG  = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [PAGE_W-1:0]   PAGE_RST_LOCAL  = 3'h1;
  localparam logic [PAGE_W-1:0]   PAGE_RST_REMOTE = 3'h0;
  localparam logic [PARAM_W-1:0]  WDV_RST         = 12'h000;
  localparam logic [STATUS_W-1:0] STATUS_RST      = 5'h00;

  // ----------------------------------------------------------------
  // wishbone register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00; // [0] read strobe [1] write strobe [4:2] sel
  localparam logic [7:0] REG_WDATA  = 8'h04;
  localparam logic [7:0] REG_RDATA  = 8'h08;
  localparam logic [7:0] REG_STAT   = 8'h0C; // [0] busy [1] cur_cfg
  localparam logic [7:0] REG_IRQ    = 8'h10; // [0] done [1] reconfig started
  localparam logic [7:0] REG_MASK   = 8'h14;
  localparam logic [7:0] REG_KICK   = 8'h18; // [0] wd reset level [1] reconfig level
  localparam int IRQ_W = 2;

  // watchdog prescale: one tick per 1 us at 50 MHz
  localparam int CLK_MHZ     = 50;
  localparam int WD_TICK_NS  = 1000;
  localparam int WD_TICK_CYC = WD_TICK_NS * CLK_MHZ / 1000;

  typedef enum logic [1:0] {
    RUP_IDLE  = 2'b00,
    RUP_CAPT  = 2'b01,
    RUP_SHIFT = 2'b10,
    RUP_UPDT  = 2'b11
  } rup_state_t;

endpackage

// ---- rtl/rup_core.sv ----
// serial shift/capture/update core holding the configuration registers
`timescale 1ns/1ps
module rup_core #(
  parameter bit LOCAL_MODE = 1'b1
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // serial port
  input  wire logic       shift_i,
  input  wire logic       capt_n_updt_i,
  input  wire logic       ser_in_i,
  output logic            ser_out_o,
  // controls and state
  input  wire logic       wd_reset_i,
  input  wire logic       reconfig_i,
  input  wire logic [4:0] err_cause_i,
  input  wire logic       is_app_i,
  output logic [2:0]      page_o,
  output logic            reconfig_start_o
);

  logic [rup_pkg::CHAIN_W-1:0]  chain_r, chain_nxt;
  logic [rup_pkg::PARAM_W-1:0]  wdv_r, wdv_nxt;
  logic                         wde_r, wde_nxt;
  logic [rup_pkg::PAGE_W-1:0]   page_r, page_nxt;
  logic [rup_pkg::STATUS_W-1:0] stat_r, stat_nxt;
  logic [rup_pkg::PARAM_W-1:0]  wdcnt_r, wdcnt_nxt;
  logic [5:0]                   pre_r, pre_nxt;
  logic                         req_d_r, req_d_nxt;
  logic                         start;

  always_comb begin
    chain_nxt = chain_r;
    wdv_nxt   = wdv_r;
    wde_nxt   = wde_r;
    page_nxt  = page_r;
    stat_nxt  = stat_r | err_cause_i;
    pre_nxt   = pre_r;
    wdcnt_nxt = wdcnt_r;
    req_d_nxt = reconfig_i;
    start     = reconfig_i & ~req_d_r;
    if (shift_i) begin
      chain_nxt = {ser_in_i, chain_r[rup_pkg::CHAIN_W-1:1]};
    end else if (capt_n_updt_i) begin
      chain_nxt = {stat_r, is_app_i, page_r, wde_r, wdv_r};
    end else if (!is_app_i) begin
      // update only takes effect in the factory image
      wdv_nxt  = chain_r[rup_pkg::POS_WDV +: rup_pkg::PARAM_W];
      wde_nxt  = chain_r[rup_pkg::POS_WDE];
      page_nxt = chain_r[rup_pkg::POS_PAGE +: rup_pkg::PAGE_W];
    end
    // watchdog counts in microsecond ticks while enabled in an application
    if (wd_reset_i || !wde_r || !is_app_i) begin
      wdcnt_nxt = '0;
      pre_nxt   = '0;
    end else if (pre_r == 6'(rup_pkg::WD_TICK_CYC - 1)) begin
      pre_nxt = '0;
      if (wdcnt_r == wdv_r) begin
        stat_nxt[rup_pkg::CAUSE_WDOG] = 1'b1;
        start = 1'b1;
      end else begin
        wdcnt_nxt = wdcnt_r + 12'h001;
      end
    end else begin
      pre_nxt = pre_r + 6'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain_r <= '0;
      wdv_r   <= rup_pkg::WDV_RST;
      wde_r   <= 1'b0;
      page_r  <= LOCAL_MODE ? rup_pkg::PAGE_RST_LOCAL : rup_pkg::PAGE_RST_REMOTE;
      stat_r  <= rup_pkg::STATUS_RST;
      wdcnt_r <= '0;
      pre_r   <= '0;
      req_d_r <= 1'b0;
      reconfig_start_o <= 1'b0;
    end else begin
      chain_r <= chain_nxt;
      wdv_r   <= wdv_nxt;
      wde_r   <= wde_nxt;
      page_r  <= page_nxt;
      stat_r  <= stat_nxt;
      wdcnt_r <= wdcnt_nxt;
      pre_r   <= pre_nxt;
      req_d_r <= req_d_nxt;
      reconfig_start_o <= start;
    end
  end

  assign ser_out_o = chain_r[0];
  assign page_o    = page_r;

endmodule

// ---- rtl/rup_top.sv ----
// remote update parameter block: wishbone slave, parameter sequencer, irq
//
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module rup_top #(
  parameter bit LOCAL_MODE = 1'b1
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // device state
  input  wire logic [4:0]  err_cause_i,
  input  wire logic        factory_or_application_flag_i,
  // pins and events
  output logic [2:0]       page_o,
  output logic             reconfig_start_o,
  output logic             irq_o
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [2:0]                  psel_r, psel_nxt;
  logic [rup_pkg::PARAM_W-1:0] wdata_r, wdata_nxt;
  logic [rup_pkg::PARAM_W-1:0] rdata_r, rdata_nxt;
  logic [1:0]                  kick_r, kick_nxt;
  logic [rup_pkg::IRQ_W-1:0]   irq_r, irq_nxt;
  logic [rup_pkg::IRQ_W-1:0]   mask_r, mask_nxt;
  logic                        ack_r, ack_nxt;
  logic [31:0]                 dat_r, dat_nxt;

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  rup_pkg::rup_state_t         st_r, st_nxt;
  logic [4:0]                  cnt_r, cnt_nxt;
  logic                        is_rd_r, is_rd_nxt;
  logic [rup_pkg::CHAIN_W-1:0] img_r, img_nxt;
  logic                        shift, capt, ser_in, ser_out, done;
  logic [2:0]                  page_w;
  logic                        start_w;

  wire busy    = (st_r != rup_pkg::RUP_IDLE);
  wire acc     = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr      = acc & wb_we_i;
  wire is_app  = factory_or_application_flag_i;

  // ----------------------------------------------------------------
  // serial core
  // ----------------------------------------------------------------
  rup_core #(
    .LOCAL_MODE (LOCAL_MODE)
  ) u_core (
    .clk_i            (clk_i),
    .rst_n_i          (rst_n_i),
    .shift_i          (shift),
    .capt_n_updt_i    (capt),
    .ser_in_i         (ser_in),
    .ser_out_o        (ser_out),
    .wd_reset_i       (kick_r[0]),
    .reconfig_i       (kick_r[1] & ~busy),
    .err_cause_i      (err_cause_i),
    .is_app_i         (is_app),
    .page_o           (page_w),
    .reconfig_start_o (start_w)
  );

  // ----------------------------------------------------------------
  // parameter sequencer: capture, shift chain out, optionally update
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    is_rd_nxt = is_rd_r;
    img_nxt   = img_r;
    rdata_nxt = rdata_r;
    shift     = 1'b0;
    // idle keeps capturing, so only a write's finish cycle can update the registers
    capt      = 1'b1;
    ser_in    = 1'b0;
    done      = 1'b0;
    case (st_r)
      rup_pkg::RUP_IDLE: begin
        if (wr && wb_adr_i == rup_pkg::REG_CTRL && wb_sel_i[0] && |wb_dat_i[1:0]) begin
          is_rd_nxt = wb_dat_i[0];
          st_nxt    = rup_pkg::RUP_CAPT;
        end
      end
      rup_pkg::RUP_CAPT: begin
        capt    = 1'b1;
        cnt_nxt = '0;
        st_nxt  = rup_pkg::RUP_SHIFT;
      end
      rup_pkg::RUP_SHIFT: begin
        shift   = 1'b1;
        // rotate the captured image back in; a write to wd_value, wd_en or page swaps in its own field bits
        ser_in  = ser_out;
        if (!is_rd_r && psel_r == rup_pkg::SEL_WD_VALUE) begin
          if (cnt_r < 5'(rup_pkg::POS_WDV + rup_pkg::PARAM_W)) begin
            ser_in = wdata_r[4'(cnt_r - 5'(rup_pkg::POS_WDV))];
          end
        end else if (!is_rd_r && psel_r == rup_pkg::SEL_WD_EN) begin
          if (cnt_r == 5'(rup_pkg::POS_WDE)) begin
            ser_in = wdata_r[0];
          end
        end else if (!is_rd_r && psel_r == rup_pkg::SEL_PAGE) begin
          if (cnt_r >= 5'(rup_pkg::POS_PAGE) && cnt_r < 5'(rup_pkg::POS_CFG)) begin
            ser_in = wdata_r[2'(cnt_r - 5'(rup_pkg::POS_PAGE))];
          end
        end
        img_nxt = {ser_out, img_r[rup_pkg::CHAIN_W-1:1]};
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == 5'(rup_pkg::CHAIN_W - 1)) begin
          st_nxt = rup_pkg::RUP_UPDT;
        end
      end
      default: begin
        // img_r now holds the captured chain
        st_nxt = rup_pkg::RUP_IDLE;
        done   = 1'b1;
        if (is_rd_r) begin
          if (psel_r == rup_pkg::SEL_STATUS) begin
            rdata_nxt = {7'h00, img_r[rup_pkg::POS_STAT +: 5]};
          end else if (psel_r == rup_pkg::SEL_WD_VALUE) begin
            rdata_nxt = img_r[rup_pkg::POS_WDV +: 12];
          end else if (psel_r == rup_pkg::SEL_WD_EN) begin
            rdata_nxt = {11'h000, img_r[rup_pkg::POS_WDE]};
          end else if (psel_r == rup_pkg::SEL_PAGE) begin
            rdata_nxt = {9'h000, img_r[rup_pkg::POS_PAGE +: 3]};
          end else if (psel_r == rup_pkg::SEL_CUR_CFG) begin
            rdata_nxt = {11'h000, img_r[rup_pkg::POS_CFG]};
          end else begin
            rdata_nxt = '0;
          end
        end else begin
          // write: shift and capture both low commit the patched chain (factory image only)
          capt = 1'b0;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // wishbone slave and interrupt
  // ----------------------------------------------------------------
  always_comb begin
    psel_nxt  = psel_r;
    wdata_nxt = wdata_r;
    kick_nxt  = kick_r;
    mask_nxt  = mask_r;
    irq_nxt   = irq_r;
    ack_nxt   = acc;
    dat_nxt   = dat_r;
    if (wr && !busy) begin
      if (wb_adr_i == rup_pkg::REG_CTRL && wb_sel_i[0]) begin
        psel_nxt = wb_dat_i[4:2];
      end else if (wb_adr_i == rup_pkg::REG_WDATA && wb_sel_i[1:0] == 2'b11) begin
        wdata_nxt = wb_dat_i[11:0];
      end
    end
    if (wr) begin
      if (wb_adr_i == rup_pkg::REG_IRQ && wb_sel_i[0]) begin
        irq_nxt = irq_r & ~wb_dat_i[rup_pkg::IRQ_W-1:0];
      end else if (wb_adr_i == rup_pkg::REG_MASK && wb_sel_i[0]) begin
        mask_nxt = wb_dat_i[rup_pkg::IRQ_W-1:0];
      end else if (wb_adr_i == rup_pkg::REG_KICK && wb_sel_i[0]) begin
        kick_nxt = wb_dat_i[1:0];
      end
    end
    // set wins over a clear in the same cycle
    irq_nxt = irq_nxt | {start_w, done};
    if (acc && !wb_we_i) begin
      if (wb_adr_i == rup_pkg::REG_CTRL) begin
        dat_nxt = {27'h0, psel_r, 2'b00};
      end else if (wb_adr_i == rup_pkg::REG_WDATA) begin
        dat_nxt = {20'h0, wdata_r};
      end else if (wb_adr_i == rup_pkg::REG_RDATA) begin
        dat_nxt = {20'h0, rdata_r};
      end else if (wb_adr_i == rup_pkg::REG_STAT) begin
        dat_nxt = {30'h0, is_app, busy};
      end else if (wb_adr_i == rup_pkg::REG_IRQ) begin
        dat_nxt = {30'h0, irq_r};
      end else if (wb_adr_i == rup_pkg::REG_MASK) begin
        dat_nxt = {30'h0, mask_r};
      end else if (wb_adr_i == rup_pkg::REG_KICK) begin
        dat_nxt = {30'h0, kick_r};
      end else begin
        dat_nxt = '0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r    <= rup_pkg::RUP_IDLE;
      cnt_r   <= '0;
      is_rd_r <= 1'b0;
      img_r   <= '0;
      rdata_r <= '0;
      psel_r  <= '0;
      wdata_r <= '0;
      kick_r  <= '0;
      mask_r  <= '0;
      irq_r   <= '0;
      ack_r   <= 1'b0;
      dat_r   <= '0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      is_rd_r <= is_rd_nxt;
      img_r   <= img_nxt;
      rdata_r <= rdata_nxt;
      psel_r  <= psel_nxt;
      wdata_r <= wdata_nxt;
      kick_r  <= kick_nxt;
      mask_r  <= mask_nxt;
      irq_r   <= irq_nxt;
      ack_r   <= ack_nxt;
      dat_r   <= dat_nxt;
    end
  end

  assign wb_ack_o         = ack_r;
  assign wb_dat_o         = dat_r;
  assign page_o           = page_w;
  assign reconfig_start_o = start_w;
  assign irq_o            = |(irq_r & mask_r);

endmodule

// ---- testbench/rup_wbm.sv ----
// wishbone classic master model standing in for the user logic
`timescale 1ns/1ps
module rup_wbm (
  // clock
  input  wire logic        clk_i,
  // bus
  output logic             cyc_o,
  output logic             stb_o,
  output logic             we_o,
  output logic [7:0]       adr_o,
  output logic [3:0]       sel_o,
  output logic [31:0]      dat_o,
  input  wire logic [31:0] dat_i,
  input  wire logic        ack_i,
  // a wait ran out
  output logic             tmo_o
);
  initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o, tmo_o} = {11'h000, 4'hF, 33'h0};

  // request held until ack is sampled high, released at that edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, dat_o} <= {2'b11, w, a, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 20);
    if (n >= 20) tmo_o <= 1'b1;
    q = dat_i;
    {cyc_o, stb_o, we_o} <= 3'h0;
  endtask

  // poll busy, bounded
  task automatic idle();
    logic [31:0] q = '1;
    repeat (40) if (q[0] !== 1'b0) xfer(1'b0, rup_pkg::REG_STAT, '0, q);
    if (q[0] !== 1'b0) tmo_o <= 1'b1;
  endtask

  // result read only once busy has dropped
  task automatic param(input logic w, input logic [2:0] s,
                       input logic [11:0] v, output logic [31:0] q);
    if (w) xfer(1'b1, rup_pkg::REG_WDATA, {20'h0_0000, v}, q);
    xfer(1'b1, rup_pkg::REG_CTRL, {27'h0, s, w, !w}, q);
    idle();
    xfer(1'b0, rup_pkg::REG_RDATA, '0, q);
  endtask
endmodule

// ---- testbench/rup_top_assertions.sv ----
// port-level checks of the parameter block
`timescale 1ns/1ps
module rup_chk #(
  parameter bit LOCAL_MODE = 1'b1
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // wishbone
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // device state and pins
  input wire logic        factory_or_application_flag_i,
  input wire logic [2:0]  page_o,
  input wire logic        reconfig_start_o
);
  localparam logic [2:0] PAGE_RST =
    LOCAL_MODE ? rup_pkg::PAGE_RST_LOCAL : rup_pkg::PAGE_RST_REMOTE;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_ack_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_taken: assert property (p_ack_taken)
    else $error("no ack one cycle after request");
  property p_ack_cause;
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i);
  endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("ack without request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_start_pulse;
    reconfig_start_o |=> !reconfig_start_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("reconfig start not a single pulse");
  property p_page_app;
    factory_or_application_flag_i && $past(factory_or_application_flag_i)
      |-> $stable(page_o);
  endproperty
  a_page_app: assert property (p_page_app)
    else $error("page changed in application image");
  property p_page_rst;
    $rose(rst_n_i) |-> page_o == PAGE_RST;
  endproperty
  a_page_rst: assert property (p_page_rst)
    else $error("page reset value wrong");
  property p_rdata_w;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == rup_pkg::REG_RDATA
      |-> wb_dat_o[31:12] == 20'h0_0000;
  endproperty
  a_rdata_w: assert property (p_rdata_w)
    else $error("read value wider than 12 bits");
  property p_stat_flag;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == rup_pkg::REG_STAT
      |-> wb_dat_o[1] == $past(factory_or_application_flag_i);
  endproperty
  a_stat_flag: assert property (p_stat_flag)
    else $error("status flag bit wrong");
endmodule

bind rup_top rup_chk #(.LOCAL_MODE(LOCAL_MODE)) rup_chk_inst (
  .clk_i, .rst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o,
  .wb_ack_o, .factory_or_application_flag_i, .page_o, .reconfig_start_o);

// ---- testbench/tb.sv ----
// self-checking bench for the remote update parameter block
`timescale 1ns/1ps
module tb;
  logic        clk_i, rst_n_i, cyc, stb, we, ack, flag, start, irq, tmo;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [4:0]  err;
  logic [2:0]  page;
  int          mismatches, checks, starts, s0;
  // w, selector, value (the expected value on reads)
  logic [15:0] rows [18] = '{
    16'h0000, 16'h2000, 16'h3000, 16'h4001, 16'h5000,
    16'h1000, 16'h6000, 16'h7000,
    16'hAABC, 16'h2ABC,
    16'hBFFF, 16'h3001,
    16'hC005, 16'h4005,
    16'h801F, 16'h0000, 16'hDFFF, 16'h5000};

  rup_top rup_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .err_cause_i(err),
    .factory_or_application_flag_i(flag), .page_o(page),
    .reconfig_start_o(start), .irq_o(irq));
  rup_wbm rup_wbm_inst (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack), .tmo_o(tmo));

  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (start === 1'b1) starts++;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    rup_wbm_inst.xfer(w, a, d, q);
  endtask
  task automatic par(input logic w, input logic [2:0] s, input logic [11:0] v);
    rup_wbm_inst.param(w, s, v, q);
  endtask
  task automatic tally_and_finish();
    if (tmo !== 1'b0) mismatches++;
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // bounded run
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    {clk_i, rst_n_i, err, flag} = '0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    check(page, 3'h1);
    bus(1'b1, rup_pkg::REG_MASK, 32'h1);
    foreach (rows[i]) begin
      par(rows[i][15], rows[i][14:12], rows[i][11:0]);
      if (!rows[i][15]) check(q, {20'h0_0000, rows[i][11:0]});
    end
    check(page, 3'h5);
    check(irq, 1'b1);
    bus(1'b1, rup_pkg::REG_IRQ, 32'h1);
    @(posedge clk_i);
    check(irq, 1'b0);
    // ----------------------------------------------------------------
    // parameter requests while busy are dropped
    // ----------------------------------------------------------------
    bus(1'b1, rup_pkg::REG_WDATA, 32'h3);
    bus(1'b1, rup_pkg::REG_CTRL, 32'h12);
    bus(1'b0, rup_pkg::REG_STAT, 32'h0);
    check(q[0], 1'b1);
    bus(1'b1, rup_pkg::REG_WDATA, 32'h7);
    bus(1'b1, rup_pkg::REG_CTRL, 32'h0A);
    rup_wbm_inst.idle();
    check(page, 3'h3);
    par(1'b0, 3'h2, 12'h0);
    check(q, 32'hABC);
    // ----------------------------------------------------------------
    // reconfiguration request edge, then watchdog in application image
    // ----------------------------------------------------------------
    s0 = starts;
    bus(1'b1, rup_pkg::REG_KICK, 32'h2);
    repeat (30) @(posedge clk_i);
    check(starts - s0, 1);
    bus(1'b0, rup_pkg::REG_IRQ, 32'h0);
    check(q[1], 1'b1);
    par(1'b1, 3'h2, 12'h2);
    bus(1'b1, rup_pkg::REG_KICK, 32'h1);
    @(posedge clk_i);
    flag <= 1'b1;
    par(1'b1, 3'h4, 12'h6);
    check(page, 3'h3);
    par(1'b0, 3'h5, 12'h0);
    check(q, 32'h1);
    s0 = starts;
    repeat (400) @(posedge clk_i);
    check(starts - s0, 0);
    bus(1'b1, rup_pkg::REG_KICK, 32'h0);
    repeat (200) @(posedge clk_i);
    check(starts > s0, 1);
    par(1'b0, 3'h0, 12'h0);
    check(q, 32'h10);
    @(posedge clk_i);
    err <= 5'h01;
    @(posedge clk_i);
    err <= 5'h00;
    par(1'b0, 3'h0, 12'h0);
    check(q, 32'h11);
    tally_and_finish();
  end
endmodule
